// ### hw/isp_port_map.vh
/*
 * constants for the test-port programming and security block.
 * assumes it is included by bare name from hw/ design files.
 */
// Contract
// R1: ready flag high done, low busy
// R2: error flag low on error, else high
// R3: status flags enabled only as a pair
// R4: flags updated only during programming
// R5: open-drain by default, push-pull optional
// R6: tool runs one chained device, others bypass
// R7: debug pin output signals internal event
// R8: debug pin input raises internal event
// R9: secured port allows only full erase
// R10: secured port refuses processor debug
// R11: full erase alone clears security bit; the code also clears it on presetn
// R12: processor keeps memory read regardless
// R13: erased cells read as all ones
// R14: tool holds external reset during programming
// R15: first load goes through the test port
// R16: pins inputs until enabling command
// R17: scan path memory die then processor
// R18: idle or disabled flags stay released
`ifndef ISP_PORT_MAP_VH
`define ISP_PORT_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_IRQ_STAT 12'h008
`define OFS_IRQ_MASK 12'h00c
`define OFS_DEBUG 12'h010

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_PUSH_PULL 0
`define CTRL_DBG_OUT 1
`define CTRL_DBG_EVENT 2
`define IRQ_DONE 0
`define IRQ_ERR 1
`define IRQ_BREAK 2
`define IRQ_ERASED 3

// ----------------------------------------
// instruction codes of the test port (4 bits)
// ----------------------------------------
`define IR_BYPASS 4'hf
`define IR_ENABLE 4'h1
`define IR_ENABLE_FLAGS 4'h2
`define IR_PROGRAM 4'h3
`define IR_READ 4'h4
`define IR_ERASE 4'h5
`define IR_DEBUG 4'h6
`define IR_SECURE 4'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define PROG_TIME_NS 2000
`define CLK_PERIOD_NS 50
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### hw/pin_sync.v
/*
 * two-stage synchroniser for pins arriving from outside pclk.
 * assumes only the second stage is read by any logic.
 */
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // data
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_reg;

   // first stage feeds only the second
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // pin_sync
`default_nettype wire

// ### hw/tap_fsm.v
/*
 * sixteen-state test access port controller, advanced on sampled tck edges.
 * assumes tck_rise is a one-cycle pulse in pclk time and tms is synchronised.
 */
`timescale 1ns/10ps
`default_nettype none
module tap_fsm (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // sampled port
   input wire tck_rise,
   input wire tms,
   // decoded state
   output reg [3:0] state_reg
);
   localparam RESET = 4'h0, IDLE = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3;
   localparam SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7;
   localparam UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb;
   localparam EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf;
   reg [3:0] state_next;

   // standard transition table
   always @* begin
      case (state_reg)
         RESET: state_next = tms ? RESET : IDLE;
         IDLE: state_next = tms ? SEL_DR : IDLE;
         SEL_DR: state_next = tms ? SEL_IR : CAP_DR;
         CAP_DR: state_next = tms ? EX1_DR : SH_DR;
         SH_DR: state_next = tms ? EX1_DR : SH_DR;
         EX1_DR: state_next = tms ? UPD_DR : PA_DR;
         PA_DR: state_next = tms ? EX2_DR : PA_DR;
         EX2_DR: state_next = tms ? UPD_DR : SH_DR;
         UPD_DR: state_next = tms ? SEL_DR : IDLE;
         SEL_IR: state_next = tms ? RESET : CAP_IR;
         CAP_IR: state_next = tms ? EX1_IR : SH_IR;
         SH_IR: state_next = tms ? EX1_IR : SH_IR;
         EX1_IR: state_next = tms ? UPD_IR : PA_IR;
         PA_IR: state_next = tms ? EX2_IR : PA_IR;
         EX2_IR: state_next = tms ? UPD_IR : SH_IR;
         UPD_IR: state_next = tms ? SEL_DR : IDLE;
         default: state_next = RESET;
      endcase
   end

   // advance only on a sampled rising tck
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= RESET;
      end else if (tck_rise) begin
         state_reg <= state_next;
      end
   end
endmodule // tap_fsm
`default_nettype wire

// ### hw/isp_port.v
/*
 * test-port programming support: two internal scan stages (memory die then
 * processor die), sideband ready/error flags, debug pin, security bit,
 * a small flash model and an apb register file with interrupt.
 * assumes tck runs far slower than pclk (400 ns against 50 ns) and that the
 * tool holds the external reset during programming.
 */
`timescale 1ns/10ps
`default_nettype none
`include "isp_port_map.vh"
module isp_port #(
   parameter ADDR_W = 6,
   parameter PROG_CYCLES = `PROG_CYCLES
) (
   // apb clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output wire irq,
   // test port pins
   input wire tck,
   input wire tms,
   input wire tdi,
   output reg tdo_out,
   output reg tdo_oe,
   // sideband status flags, two-signal pins
   output reg program_ready_flag_out,
   output reg program_ready_flag_oe,
   output reg program_error_flag_out,
   output reg program_error_flag_oe,
   // debug pin, two-way
   input wire debug_pin_in,
   output reg debug_pin_out,
   output reg debug_pin_oe,
   // external reset pin level and processor side
   input wire external_reset_pin,
   input wire proc_debug_event,
   output reg proc_break_req,
   input wire [ADDR_W-1:0] proc_rd_addr,
   output reg [7:0] proc_rd_data,
   output reg secured
);
   localparam SH_DR = 4'h4, UPD_DR = 4'h8, SH_IR = 4'hb, UPD_IR = 4'hf, RESET = 4'h0, CAP_DR = 4'h3;
   localparam DEPTH = 1 << ADDR_W;
   localparam DRW = ADDR_W + 9;

   // ----------------------------------------
   // pin sampling and tck edge detection
   // ----------------------------------------
   wire [4:0] pins_s;
   reg tck_d_reg;
   pin_sync #(.WIDTH(5)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({tck, tms, tdi, debug_pin_in, external_reset_pin}),
      .sync_out(pins_s)
   );
   wire tck_s = pins_s[4];
   wire tms_s = pins_s[3];
   wire tdi_s = pins_s[2];
   wire dbg_in_s = pins_s[1];
   wire ext_rst_s = pins_s[0];
   wire tck_rise = tck_s & ~tck_d_reg;
   wire tck_fall = ~tck_s & tck_d_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) tck_d_reg <= 1'b0;
      else tck_d_reg <= tck_s;
   end

   wire [3:0] tap_state;
   tap_fsm u_tap (
      .pclk(pclk),
      .presetn(presetn),
      .tck_rise(tck_rise),
      .tms(tms_s),
      .state_reg(tap_state)
   );

   // ----------------------------------------
   // instruction and data stages of both dies
   // ----------------------------------------
   reg [3:0] mem_ir_sh_reg, mem_ir_reg, cpu_ir_sh_reg, cpu_ir_reg;
   reg [DRW-1:0] mem_dr_reg;
   reg cpu_dr_reg;
   reg port_en_reg, flags_en_reg;
   reg [7:0] flash_mem [0:DEPTH-1];
   reg prog_busy_reg, prog_err_reg, erase_busy_reg;
   reg [15:0] prog_cnt_reg;
   reg [ADDR_W-1:0] prog_addr_reg;
   reg [7:0] prog_data_reg;
   reg ev_done, ev_err, ev_erased;

   // operation allowed on the memory die given security
   function allowed;
      input [3:0] code;
      input sec;
      begin
         allowed = !sec || code == `IR_ERASE || code == `IR_BYPASS; // see R9
      end
   endfunction

   wire mem_op = mem_ir_reg == `IR_PROGRAM || mem_ir_reg == `IR_READ || mem_ir_reg == `IR_ERASE;
   wire isp_mode = mem_op && cpu_ir_reg == `IR_BYPASS; // see R17
   wire cpu_debug = cpu_ir_reg == `IR_DEBUG && !secured; // see R10
   // serial path tdi -> memory die -> processor die -> tdo
   wire mem_tdo = (tap_state == SH_IR) ? mem_ir_sh_reg[0] :
                  (mem_ir_reg == `IR_BYPASS) ? mem_dr_reg[0] : mem_dr_reg[0]; // see R17
   wire cpu_tdo = (tap_state == SH_IR) ? cpu_ir_sh_reg[0] : cpu_dr_reg;
   wire mem_bypass = mem_ir_reg == `IR_BYPASS || !allowed(mem_ir_reg, secured);

   // scan shifting on tck rise, instruction update on update state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ir_sh_reg <= 4'h0;
         cpu_ir_sh_reg <= 4'h0;
         mem_ir_reg <= `IR_BYPASS;
         cpu_ir_reg <= `IR_BYPASS;
         mem_dr_reg <= {DRW{1'b0}};
         cpu_dr_reg <= 1'b0;
         port_en_reg <= 1'b0;
         flags_en_reg <= 1'b0;
      end else if (tck_rise) begin
         case (tap_state)
            RESET: begin
               mem_ir_reg <= `IR_BYPASS;
               cpu_ir_reg <= `IR_BYPASS;
            end
            SH_IR: begin
               cpu_ir_sh_reg <= {mem_ir_sh_reg[0], cpu_ir_sh_reg[3:1]};
               mem_ir_sh_reg <= {tdi_s, mem_ir_sh_reg[3:1]};
            end
            UPD_IR: begin
               mem_ir_reg <= mem_ir_sh_reg;
               cpu_ir_reg <= cpu_ir_sh_reg;
               if (mem_ir_sh_reg == `IR_ENABLE || mem_ir_sh_reg == `IR_ENABLE_FLAGS) begin
                  port_en_reg <= 1'b1; // see R16
                  flags_en_reg <= mem_ir_sh_reg == `IR_ENABLE_FLAGS; // see R3
               end
            end
            CAP_DR: begin
               if (mem_ir_reg == `IR_READ && allowed(`IR_READ, secured))
                  mem_dr_reg <= {1'b0, mem_dr_reg[DRW-2:8], flash_mem[mem_dr_reg[DRW-2:8]]};
               cpu_dr_reg <= 1'b0;
            end
            SH_DR: begin
               cpu_dr_reg <= mem_tdo; // see R6
               if (mem_bypass) mem_dr_reg <= {{(DRW-1){1'b0}}, tdi_s};
               else mem_dr_reg <= {tdi_s, mem_dr_reg[DRW-1:1]};
            end
            default: ;
         endcase
      end
   end

   // tdo driven on falling tck once the port is enabled
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdo_out <= 1'b0;
         tdo_oe <= 1'b0;
      end else begin
         tdo_oe <= port_en_reg; // see R16
         if (tck_fall) tdo_out <= cpu_tdo;
      end
   end

   // ----------------------------------------
   // flash model, programming and erase engine
   // ----------------------------------------
   integer i;
   wire start_prog = tck_rise && tap_state == UPD_DR && mem_ir_reg == `IR_PROGRAM && !secured && !prog_busy_reg;
   wire start_erase = tck_rise && tap_state == UPD_DR && mem_ir_reg == `IR_ERASE && !prog_busy_reg;
   wire start_secure = tck_rise && tap_state == UPD_DR && mem_ir_reg == `IR_SECURE && !secured;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_busy_reg <= 1'b0;
         erase_busy_reg <= 1'b0;
         prog_err_reg <= 1'b0;
         prog_cnt_reg <= 16'h0000;
         prog_addr_reg <= {ADDR_W{1'b0}};
         prog_data_reg <= 8'hff;
         secured <= 1'b0;
         ev_done <= 1'b0;
         ev_err <= 1'b0;
         ev_erased <= 1'b0;
      end else begin
         ev_done <= 1'b0;
         ev_err <= 1'b0;
         ev_erased <= 1'b0;
         if (start_secure) secured <= 1'b1;
         if (start_prog || start_erase) begin
            prog_busy_reg <= 1'b1;
            erase_busy_reg <= start_erase;
            prog_err_reg <= 1'b0;
            prog_cnt_reg <= PROG_CYCLES[15:0];
            prog_addr_reg <= mem_dr_reg[DRW-2:8];
            prog_data_reg <= mem_dr_reg[7:0];
         end else if (prog_busy_reg) begin
            if (prog_cnt_reg > 16'h0001) begin
               prog_cnt_reg <= prog_cnt_reg - 16'h0001;
            end else begin
               prog_busy_reg <= 1'b0;
               ev_done <= 1'b1;
               if (erase_busy_reg) begin
                  secured <= 1'b0; // see R11
                  ev_erased <= 1'b1;
               end else if ((flash_mem[prog_addr_reg] & prog_data_reg) != prog_data_reg) begin
                  prog_err_reg <= 1'b1; // a cell cannot go 0 to 1 without erase
                  ev_err <= 1'b1;
               end
            end
         end
      end
   end

   // memory array: all ones when erased
   always @(posedge pclk) begin
      if (!presetn) begin
         for (i = 0; i < DEPTH; i = i + 1) flash_mem[i] <= 8'hff; // see R13
      end else if (prog_busy_reg && prog_cnt_reg == 16'h0001) begin
         if (erase_busy_reg) begin
            for (i = 0; i < DEPTH; i = i + 1) flash_mem[i] <= 8'hff; // see R13
         end else begin
            flash_mem[prog_addr_reg] <= flash_mem[prog_addr_reg] & prog_data_reg;
         end
      end
   end

   // processor read port ignores the security bit
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) proc_rd_data <= 8'h00;
      else proc_rd_data <= flash_mem[proc_rd_addr]; // see R12
   end

   // ----------------------------------------
   // apb registers and interrupt
   // ----------------------------------------
   reg [2:0] ctrl_reg;
   reg [3:0] irq_stat_reg, irq_mask_reg;
   wire wr = psel && penable && pwrite;
   wire dbg_break = !ctrl_reg[`CTRL_DBG_OUT] && !dbg_in_s && cpu_debug;
   wire [3:0] ev_vec = {ev_erased, dbg_break, ev_err, ev_done};
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= 3'h0;
         irq_stat_reg <= 4'h0;
         irq_mask_reg <= 4'h0;
      end else begin
         if (wr && paddr == `OFS_CTRL) ctrl_reg <= pwdata[2:0];
         if (wr && paddr == `OFS_IRQ_MASK) irq_mask_reg <= pwdata[3:0];
         // set wins over write-one-to-clear
         if (wr && paddr == `OFS_IRQ_STAT) irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | ev_vec;
         else irq_stat_reg <= irq_stat_reg | ev_vec;
      end
   end

   always @* begin
      case (paddr)
         `OFS_CTRL: prdata = {29'h0, ctrl_reg};
         `OFS_STATUS: prdata = {26'h0, tdo_oe, flags_en_reg, secured, isp_mode, prog_err_reg, prog_busy_reg};
         `OFS_IRQ_STAT: prdata = {28'h0, irq_stat_reg};
         `OFS_IRQ_MASK: prdata = {28'h0, irq_mask_reg};
         `OFS_DEBUG: prdata = {31'h0, dbg_in_s};
         default: prdata = 32'h0;
      endcase
   end

   // ----------------------------------------
   // sideband flags and debug pin drive
   // ----------------------------------------
   wire flags_live = flags_en_reg && isp_mode && ext_rst_s; // see R4 R14
   wire rdy_val = flags_live ? !prog_busy_reg : 1'b1; // see R1 R18
   wire err_val = flags_live ? !prog_err_reg : 1'b1; // see R2 R18

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_ready_flag_out <= 1'b0;
         program_ready_flag_oe <= 1'b0;
         program_error_flag_out <= 1'b0;
         program_error_flag_oe <= 1'b0;
         debug_pin_out <= 1'b0;
         debug_pin_oe <= 1'b0;
         proc_break_req <= 1'b0;
      end else begin
         if (ctrl_reg[`CTRL_PUSH_PULL] && flags_live) begin // see R5
            program_ready_flag_out <= rdy_val;
            program_ready_flag_oe <= 1'b1;
            program_error_flag_out <= err_val;
            program_error_flag_oe <= 1'b1;
         end else begin
            program_ready_flag_out <= 1'b0;
            program_ready_flag_oe <= !rdy_val; // see R5 R18
            program_error_flag_out <= 1'b0;
            program_error_flag_oe <= !err_val;
         end
         debug_pin_oe <= ctrl_reg[`CTRL_DBG_OUT];
         debug_pin_out <= !(proc_debug_event && cpu_debug); // see R7
         proc_break_req <= dbg_break; // see R8
      end
   end
endmodule // isp_port
`default_nettype wire

// ### bench/isp_port_asserts.sv
/* port checker for isp_port: apb answer, flag pairing, busy length, debug pin.
   assumes it is bound into isp_port and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module isp_port_asserts #(
   parameter PROG_CYCLES = 40
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // port and flags
   input wire logic tdo_oe,
   input wire logic program_ready_flag_out,
   input wire logic program_ready_flag_oe,
   input wire logic program_error_flag_out,
   input wire logic program_error_flag_oe,
   // debug pin and security
   input wire logic debug_pin_oe,
   input wire logic debug_pin_out,
   input wire logic proc_debug_event,
   input wire logic proc_break_req,
   input wire logic secured
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // busy length, a stuck write would hold the ready flag low forever
   // ----------------------------------------
   logic [15:0] busy_cnt_reg;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_cnt_reg <= 16'h0000;
      end else if (program_ready_flag_oe && !program_ready_flag_out) begin
         busy_cnt_reg <= busy_cnt_reg + 16'h0001;
      end else begin
         busy_cnt_reg <= 16'h0000;
      end
   end
   sequence s_secure_held;
      secured [*2];
   endsequence
   sequence s_trigger;
      proc_debug_event && debug_pin_oe;
   endsequence
   a_apb_ready: assert property (psel && penable |-> pready)
      else $error("apb access not answered");
   a_apb_no_error: assert property (psel && penable |-> !pslverr)
      else $error("apb error response");
   a_flags_paired: assert property (program_ready_flag_oe && program_ready_flag_out |-> program_error_flag_oe)
      else $error("push-pull ready flag without error flag");
   a_flags_need_enable: assert property (!tdo_oe |-> !program_ready_flag_oe && !program_error_flag_oe)
      else $error("flag driven before port enable");
   a_busy_bounded: assert property (busy_cnt_reg <= PROG_CYCLES + 4)
      else $error("busy longer than a write");
   a_secure_no_break: assert property (s_secure_held |-> !proc_break_req)
      else $error("break request while secured");
   a_trigger_out_low: assert property (s_trigger |=> !debug_pin_out)
      else $error("debug event not on pin");
   a_break_input_mode: assert property ($rose(proc_break_req) |-> !debug_pin_oe)
      else $error("break request in output mode");
endmodule // isp_port_asserts
bind isp_port isp_port_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .tdo_oe(tdo_oe),
   .program_ready_flag_out(program_ready_flag_out), .program_ready_flag_oe(program_ready_flag_oe),
   .program_error_flag_out(program_error_flag_out), .program_error_flag_oe(program_error_flag_oe),
   .debug_pin_oe(debug_pin_oe), .debug_pin_out(debug_pin_out), .proc_debug_event(proc_debug_event),
   .proc_break_req(proc_break_req), .secured(secured)
);
`default_nettype wire

// ### bench/isp_tool_model.sv
/* model of the external programming tool on the test port.
   assumes one task runs at a time; tck idles low between scans. */
`timescale 1ns/10ps
`default_nettype none
`include "isp_port_map.vh"
module isp_tool_model (
   // test port toward the device
   output logic tck,
   output logic tms,
   output logic tdi,
   // reset line of the tool
   output logic external_reset_pin
);
   // reset is held for the whole session
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      external_reset_pin = 1'b1;
   end
   // one tck period, tms and tdi move while tck is low
   task automatic step(input logic m, input logic d);
      tms = m;
      tdi = d;
      #200 tck = 1'b1;
      #200 tck = 1'b0;
   endtask
   // five ones reach reset from anywhere, then park in idle
   task automatic tap_reset();
      int i;
      #13;
      for (i = 0; i < 5; i++) step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask
   // idle to idle scan; the odd offset keeps tck out of phase with pclk
   task automatic scan(input logic ir, input logic [15:0] bits, input int n);
      int i;
      #13;
      step(1'b1, ~tdi);
      if (ir) step(1'b1, ~tdi);
      step(1'b0, ~tdi);
      step(1'b0, ~tdi);
      for (i = 0; i < n; i++) step(i == n - 1, bits[i]);
      step(1'b1, ~tdi);
      step(1'b0, ~tdi);
   endtask
   // cpu die sits nearest tdo so its code goes in first
   task automatic load_ir(input logic [3:0] mem_code, input logic [3:0] cpu_code);
      scan(1'b1, {8'h00, mem_code, cpu_code}, 8);
   endtask
   // leading bit fills the bypass stage of the cpu die
   task automatic program_word(input logic [5:0] a, input logic [7:0] d);
      load_ir(`IR_PROGRAM, `IR_BYPASS);
      scan(1'b0, {1'b0, a, d, 1'b0}, 16);
   endtask
endmodule // isp_tool_model
`default_nettype wire

// ### bench/isp_port_tb_top.sv
/* self-checking bench for isp_port with the tool model on the test port.
   assumes hw/ on the include path; flag and debug pins have pull-ups. */
`timescale 1ns/10ps
`default_nettype none
`include "isp_port_map.vh"
module isp_port_tb_top;
   logic pclk, presetn, psel, penable, pwrite, proc_debug_event, pull_low;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [5:0] proc_rd_addr;
   wire [31:0] prdata;
   wire [7:0] proc_rd_data;
   wire pready, pslverr, irq, tck, tms, tdi, tdo_out, tdo_oe, ext_rst, secured, proc_break_req;
   wire program_ready_flag_out, program_ready_flag_oe, program_error_flag_out, program_error_flag_oe;
   wire debug_pin_in, debug_pin_out, debug_pin_oe, ready_lvl, err_lvl;
   int bad_count = 0;
   int num_checks = 0;
   // pin levels with the board pull-ups
   assign ready_lvl = program_ready_flag_oe ? program_ready_flag_out : 1'b1;
   assign err_lvl = program_error_flag_oe ? program_error_flag_out : 1'b1;
   assign debug_pin_in = debug_pin_oe ? debug_pin_out : !pull_low;
   always #25 pclk = ~pclk;
   isp_tool_model tool (.tck(tck), .tms(tms), .tdi(tdi), .external_reset_pin(ext_rst));
   isp_port #(.ADDR_W(6), .PROG_CYCLES(40)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
      .program_ready_flag_out(program_ready_flag_out), .program_ready_flag_oe(program_ready_flag_oe),
      .program_error_flag_out(program_error_flag_out), .program_error_flag_oe(program_error_flag_oe),
      .debug_pin_in(debug_pin_in), .debug_pin_out(debug_pin_out), .debug_pin_oe(debug_pin_oe),
      .external_reset_pin(ext_rst), .proc_debug_event(proc_debug_event),
      .proc_break_req(proc_break_req), .proc_rd_addr(proc_rd_addr),
      .proc_rd_data(proc_rd_data), .secured(secured)
   );
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer; returns at the falling edge so outputs have settled
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) bad_count++;
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   task automatic wait_ready();
      int n;
      for (n = 0; n < 200 && ready_lvl !== 1'b1; n++) @(negedge pclk);
   endtask
   task automatic t_reset();
      check("tdo enable", 0, tdo_oe);
      check("flag enables", 0, {program_ready_flag_oe, program_error_flag_oe});
      apb(0, `OFS_STATUS, 0, rd);
      check("status", 0, rd);
      apb(1, `OFS_CTRL, 32'h3, rd);
      apb(0, `OFS_CTRL, 0, rd);
      check("ctrl", 32'h3, rd);
      apb(1, 12'h020, 32'hffffffff, rd);
      apb(0, 12'h020, 0, rd);
      check("unmapped", 0, rd);
      apb(1, `OFS_CTRL, 0, rd);
   endtask
   task automatic t_program();
      tool.tap_reset();
      tool.scan(1'b0, 16'h0001, 2);
      check("tdo two stages", 1, tdo_out);
      tool.load_ir(`IR_ENABLE_FLAGS, `IR_BYPASS);
      check("tdo enable on", 1, tdo_oe);
      tool.program_word(6'h05, 8'h5a);
      check("ready busy", 0, ready_lvl);
      wait_ready();
      check("ready done", 1, ready_lvl);
      check("no error", 1, err_lvl);
      check("masked irq", 0, irq);
      apb(1, `OFS_IRQ_MASK, 32'h1, rd);
      check("done irq", 1, irq);
      apb(1, `OFS_IRQ_STAT, 32'h1, rd);
      check("irq cleared", 0, irq);
      @(posedge pclk) proc_rd_addr <= 6'h05;
      repeat (3) @(negedge pclk);
      check("cpu read", 8'h5a, proc_rd_data);
   endtask
   task automatic t_error();
      apb(1, `OFS_IRQ_MASK, 0, rd);
      tool.program_word(6'h05, 8'hff);
      wait_ready();
      check("error flag", 0, err_lvl);
      check("error masked", 0, irq);
      apb(0, `OFS_IRQ_STAT, 0, rd);
      check("error status", 32'h2, rd & 32'h2);
      apb(1, `OFS_IRQ_STAT, 32'h2, rd);
   endtask
   task automatic t_push_pull();
      apb(1, `OFS_CTRL, 32'h1, rd);
      tool.program_word(6'h06, 8'h00);
      check("pp busy", 2'b10, {program_ready_flag_oe, program_ready_flag_out});
      wait_ready();
      check("pp ready", 2'b11, {program_ready_flag_oe, program_ready_flag_out});
      check("pp pair", 1, program_error_flag_oe);
      apb(1, `OFS_CTRL, 0, rd);
      @(negedge pclk);
      check("od idle", 0, {program_ready_flag_oe, program_ready_flag_out});
   endtask
   task automatic t_secure();
      int n;
      tool.load_ir(`IR_SECURE, `IR_BYPASS);
      tool.scan(1'b0, 16'h0000, 1);
      check("secured", 1, secured);
      tool.program_word(6'h05, 8'h00);
      check("write refused", 1, ready_lvl);
      check("cpu read secured", 8'h5a, proc_rd_data);
      tool.load_ir(`IR_BYPASS, `IR_DEBUG);
      @(posedge pclk) pull_low <= 1'b1;
      repeat (10) @(negedge pclk);
      check("break refused", 0, proc_break_req);
      @(posedge pclk) pull_low <= 1'b0;
      tool.load_ir(`IR_ERASE, `IR_BYPASS);
      tool.scan(1'b0, 16'h0000, 1);
      for (n = 0; n < 200 && secured !== 1'b0; n++) @(negedge pclk);
      wait_ready();
      check("secure cleared", 0, secured);
      check("erased cell", 8'hff, proc_rd_data);
   endtask
   task automatic t_debug();
      int n;
      tool.load_ir(`IR_BYPASS, `IR_DEBUG);
      @(posedge pclk) pull_low <= 1'b1;
      for (n = 0; n < 20 && proc_break_req !== 1'b1; n++) @(negedge pclk);
      check("break request", 1, proc_break_req);
      check("flag idle debug", 0, program_ready_flag_oe);
      @(posedge pclk) pull_low <= 1'b0;
      apb(1, `OFS_CTRL, 32'h2, rd);
      @(posedge pclk) proc_debug_event <= 1'b1;
      repeat (3) @(negedge pclk);
      check("trigger out", 2'b10, {debug_pin_oe, debug_pin_out});
      @(posedge pclk) proc_debug_event <= 1'b0;
      apb(1, `OFS_CTRL, 0, rd);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // watchdog, more than ten times the expected run
   initial begin
      #1500000;
      bad_count++;
      results();
   end
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, proc_debug_event, pull_low} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      proc_rd_addr = 6'h00;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      t_reset();
      t_program();
      t_error();
      t_push_pull();
      t_secure();
      t_debug();
      results();
   end
endmodule // isp_port_tb_top
`default_nettype wire
